// >>> adc_trig_defines.svh
// Offsets, field positions, reset values and counts of the conversion trigger control.
// Assumes a byte-addressed 32-bit register port with one aligned word per register.
`ifndef ADC_TRIG_DEFINES_SVH
`define ADC_TRIG_DEFINES_SVH
`define ADDR_CTRL0     8'h00
`define ADDR_CTRL1     8'h04
`define ADDR_STATUS    8'h08
`define ADDR_RESULT    8'h0C
`define ADDR_IFG       8'h10
`define ADDR_IE        8'h14
`define ADDR_DMA       8'h18
`define EN_POS         0
`define PWR_POS        1
`define SC_POS         2
`define SHP_POS        3
`define SHT_LSB        4
`define MODE_LSB       0
`define TSEL_LSB       2
`define CSEL_LSB       5
`define DIV_LSB        7
`define VSEL_LSB       10
`define SLEN_LSB       14
`define DMA_EN_POS     0
`define DMA_LVL_POS    1
`define IFG_CONV       0
`define IFG_SEQ        1
`define IFG_OVF        2
`define IFG_RST        3'h0
`define IE_RST         3'h0
`define RESULT_RST     12'h000
`define CONV_TICKS     5'h0E
`define MIN_EXT_SAMPLE 4'h6
`define CSEL_OSC       2'h0
`define CSEL_SUBSYS    2'h3
`define TSEL_SW        3'h0
`define TSEL_FIRST_B   3'h3
`endif

// >>> adc_trig_pkg.sv
// Types of the conversion trigger control.
// Assumes adc_trig_defines.svh holds the register numbers; the state and mode codes are set here.
package adc_trig_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONV   = 4'h4,
    ST_HALT   = 4'h8
  } conv_state_t;
  typedef enum logic [1:0] {
    MODE_SINGLE     = 2'h0,
    MODE_SEQ        = 2'h1,
    MODE_REP_SINGLE = 2'h2,
    MODE_REP_SEQ    = 2'h3
  } seq_mode_t;
endpackage

// >>> adc_trig_ctrl.sv
// Conversion enable, trigger, sequencing, busy and DMA request logic of a 12-bit converter.
// Assumes timer trigger pins are asynchronous; all other inputs share clk.
`timescale 1ns/1ps
`include "adc_trig_defines.svh"
module adc_trig_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic [4:0]  timer_trig,
  input  wire logic        deep_sleep_three_four,
  input  wire logic        reference_power_bit,
  input  wire logic        subsystem_clock_gate_bit,
  input  wire logic [11:0] sample_data,
  input  wire logic        dma_ack,
  output logic             dma_req,
  output logic      [11:0] dma_data,
  output logic             conversion_busy_flag,
  output logic             irq
);
  typedef struct packed {
    adc_trig_pkg::conv_state_t st;
    logic                      en;
    logic                      pwr;
    logic                      sc;
    logic                      shp;
    logic [3:0]                sht;
    adc_trig_pkg::seq_mode_t   mode;
    logic [2:0]                tsel;
    logic [1:0]                csel;
    logic [2:0]                div;
    logic [3:0]                vsel;
    logic [3:0]                slen;
    logic [2:0]                ifg;
    logic [2:0]                ie;
    logic                      dma_en;
    logic                      dma_lvl;
    logic                      dma_req;
    logic                      dma_stuck;
    logic                      cpu_read;
    logic                      armed;
    logic                      hung;
    logic                      ext_used;
    logic [2:0]                divc;
    logic [4:0]                cnt;
    logic [3:0]                chan;
    logic [11:0]               result;
    logic [31:0]               rdata;
    logic [4:0]                trig_s1;
    logic [4:0]                trig_s2;
    logic [4:0]                trig_d;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t nxt;

  // Buffered reference codes are the odd ones except 11.
  function automatic logic ref_buffered(input logic [3:0] code);
    ref_buffered = code[0] && (code != 4'hB);
  endfunction

  function automatic logic multi_channel(input adc_trig_pkg::seq_mode_t m);
    multi_channel = (m == adc_trig_pkg::MODE_SEQ) || (m == adc_trig_pkg::MODE_REP_SEQ);
  endfunction

  logic       tick;
  logic       lp_block;
  logic       ext_start;
  logic       sw_start;
  logic       start;
  logic       active;
  logic       conv_end;
  logic       seq_end;
  logic       suspect;
  logic [2:0] tidx;
  logic [3:0] sample_ticks;
  logic [31:0] rd_val;

  assign tick         = q.pwr && (q.divc == q.div);
  assign tidx         = q.tsel - 3'h1;
  // Low-power oscillator case passes only the first two timer inputs.
  assign lp_block     = (q.csel == `CSEL_OSC) && !reference_power_bit && deep_sleep_three_four
                        && (q.tsel >= `TSEL_FIRST_B);
  assign ext_start    = (q.tsel != `TSEL_SW) && (q.tsel <= 3'h5) && !lp_block && q.armed
                        && q.en && q.pwr && q.trig_s2[tidx] && !q.trig_d[tidx];
  assign sw_start     = (q.tsel == `TSEL_SW) && q.sc && q.en && q.pwr;
  assign start        = ext_start || sw_start;
  assign active       = (q.st == adc_trig_pkg::ST_SAMPLE) || (q.st == adc_trig_pkg::ST_CONV);
  assign conv_end     = (q.st == adc_trig_pkg::ST_CONV) && tick && (q.cnt == 5'h01);
  assign seq_end      = !multi_channel(q.mode) || (q.chan == q.slen);
  assign sample_ticks = (q.sht == 4'h0) ? 4'h1 : q.sht;
  // Extended sampling on an unbuffered reference below six cycles is flagged as unreliable.
  assign suspect      = !q.shp && !ref_buffered(q.vsel) && (sample_ticks < `MIN_EXT_SAMPLE);

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (addr)
      `ADDR_CTRL0:  rd_val = {24'h0, q.sht, q.shp, q.sc, q.pwr, q.en};
      `ADDR_CTRL1:  rd_val = {14'h0, q.slen, q.vsel, q.div, q.csel, q.tsel, q.mode};
      `ADDR_STATUS: rd_val = {27'h0, q.dma_stuck, suspect, q.hung,
                              (q.st == adc_trig_pkg::ST_HALT), conversion_busy_flag};
      `ADDR_RESULT: rd_val = {20'h0, q.result};
      `ADDR_IFG:    rd_val = {29'h0, q.ifg};
      `ADDR_IE:     rd_val = {29'h0, q.ie};
      `ADDR_DMA:    rd_val = {30'h0, q.dma_lvl, q.dma_en};
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt         = q;
    nxt.trig_s1 = timer_trig;
    nxt.trig_s2 = q.trig_s1;
    nxt.trig_d  = q.trig_s2;
    nxt.rdata   = rd_stb ? rd_val : 32'h0000_0000;
    nxt.divc    = (!q.pwr || tick) ? 3'h0 : q.divc + 3'h1;
    if (rd_stb && (addr == `ADDR_RESULT))
      nxt.cpu_read = 1'b1;
    // A level-triggered transfer clears the stuck edge logic; a new stuck condition wins.
    if (dma_ack && q.dma_lvl)
      nxt.dma_stuck = 1'b0;
    if (wr_stb)
    begin
      case (addr)
        `ADDR_CTRL0:
        begin
          nxt.en  = wdata[`EN_POS];
          nxt.pwr = wdata[`PWR_POS];
          nxt.sc  = wdata[`SC_POS];
          nxt.shp = wdata[`SHP_POS];
          nxt.sht = wdata[`SHT_LSB +: 4];
          if (!q.en && wdata[`EN_POS])
            nxt.armed = 1'b1;
          // Enable and start together after an external trigger lock the converter busy.
          if (!q.en && wdata[`EN_POS] && wdata[`SC_POS] && q.ext_used)
            nxt.st = adc_trig_pkg::ST_HALT;
          // Power toggled during a sequence or repeat conversion halts it.
          if (active && (wdata[`PWR_POS] != q.pwr) && (q.mode != adc_trig_pkg::MODE_SINGLE))
            nxt.st = adc_trig_pkg::ST_HALT;
        end
        `ADDR_CTRL1:
        begin
          nxt.mode = adc_trig_pkg::seq_mode_t'(wdata[`MODE_LSB +: 2]);
          nxt.tsel = wdata[`TSEL_LSB +: 3];
          nxt.csel = wdata[`CSEL_LSB +: 2];
          nxt.div  = wdata[`DIV_LSB +: 3];
          nxt.vsel = wdata[`VSEL_LSB +: 4];
          nxt.slen = wdata[`SLEN_LSB +: 4];
          // Leaving a gated subsystem clock with divide by 3, 5 or 7 hangs for good.
          if ((q.csel == `CSEL_SUBSYS) && (wdata[`CSEL_LSB +: 2] != `CSEL_SUBSYS)
              && subsystem_clock_gate_bit && !q.div[0] && (q.div != 3'h0))
          begin
            nxt.hung = 1'b1;
            nxt.st   = adc_trig_pkg::ST_HALT;
          end
        end
        `ADDR_IE:
          nxt.ie = wdata[2:0];
        `ADDR_DMA:
        begin
          nxt.dma_en  = wdata[`DMA_EN_POS];
          nxt.dma_lvl = wdata[`DMA_LVL_POS];
          // Edge mode chosen after a CPU read of the result loses its trigger.
          if (wdata[`DMA_EN_POS] && !wdata[`DMA_LVL_POS] && q.cpu_read)
          begin
            nxt.dma_stuck = 1'b1;
            nxt.cpu_read  = 1'b0;
          end
        end
        default:
          nxt.en = nxt.en;
      endcase
    end
    nxt.dma_req = q.dma_lvl ? (q.dma_req && !dma_ack) : 1'b0;
    nxt.ifg = (wr_stb && (addr == `ADDR_IFG)) ? (q.ifg & ~wdata[2:0]) : q.ifg;
    case (q.st)
      adc_trig_pkg::ST_IDLE:
        if (start)
        begin
          nxt.st       = adc_trig_pkg::ST_SAMPLE;
          nxt.cnt      = {1'b0, sample_ticks};
          nxt.chan     = 4'h0;
          nxt.ext_used = ext_start;
          if (sw_start)
            nxt.sc = 1'b0;
        end
      adc_trig_pkg::ST_SAMPLE, adc_trig_pkg::ST_CONV:
      begin
        if (tick)
          nxt.cnt = q.cnt - 5'h01;
        if (tick && (q.cnt == 5'h01) && (q.st == adc_trig_pkg::ST_SAMPLE))
        begin
          nxt.st  = adc_trig_pkg::ST_CONV;
          nxt.cnt = `CONV_TICKS;
        end
        if (conv_end)
        begin
          nxt.result         = sample_data;
          nxt.ifg[`IFG_CONV] = 1'b1;
          // Every conversion with DMA enabled requests it, also inside a sequence, unless edge mode is stuck.
          if (q.dma_en && (q.dma_lvl || !q.dma_stuck))
            nxt.dma_req = 1'b1;
          if (seq_end)
          begin
            nxt.ifg[`IFG_SEQ] = 1'b1;
            nxt.st            = adc_trig_pkg::ST_IDLE;
            if ((q.mode == adc_trig_pkg::MODE_SINGLE) || (q.mode == adc_trig_pkg::MODE_SEQ))
              nxt.armed = 1'b0;
          end
          else
          begin
            nxt.chan = q.chan + 4'h1;
            nxt.st   = adc_trig_pkg::ST_SAMPLE;
            nxt.cnt  = {1'b0, sample_ticks};
          end
        end
        if (start && (q.mode != adc_trig_pkg::MODE_SINGLE))
          nxt.st = adc_trig_pkg::ST_HALT;
        else if (start)
          nxt.ifg[`IFG_OVF] = 1'b1;
      end
      adc_trig_pkg::ST_HALT:
        if (!q.en && !q.pwr && !q.hung)
        begin
          nxt.st = adc_trig_pkg::ST_IDLE;
          nxt.sc = 1'b0;
        end
      default:
        nxt.st = adc_trig_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q        <= '0;
      q.st     <= adc_trig_pkg::ST_IDLE;
      q.mode   <= adc_trig_pkg::MODE_SINGLE;
      q.ifg    <= `IFG_RST;
      q.ie     <= `IE_RST;
      q.result <= `RESULT_RST;
    end
    else
      q <= nxt;
  end

  assign rdata                = q.rdata;
  assign dma_req              = q.dma_req;
  assign dma_data             = q.result;
  assign conversion_busy_flag = (q.st != adc_trig_pkg::ST_IDLE);
  assign irq                  = |(q.ifg & q.ie);

  sequence s_halt_off;
    (q.st == adc_trig_pkg::ST_HALT) && !q.en && !q.pwr && !q.hung;
  endsequence
  sequence s_back_idle;
    (q.st == adc_trig_pkg::ST_IDLE) && !conversion_busy_flag;
  endsequence

  a_sc_self_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == adc_trig_pkg::ST_IDLE) && sw_start && !wr_stb |=> !q.sc && conversion_busy_flag)
    else $error("software start bit did not clear at conversion start");
  a_halt_retrig: assert property (@(posedge clk) disable iff (!rst_n)
    active && start && (q.mode != adc_trig_pkg::MODE_SINGLE) |=> (q.st == adc_trig_pkg::ST_HALT))
    else $error("retrigger while busy did not halt");
  a_recover_idle: assert property (@(posedge clk) disable iff (!rst_n)
    s_halt_off |=> s_back_idle)
    else $error("halted converter did not recover");
  a_lp_block: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == adc_trig_pkg::ST_IDLE) && lp_block |=> (q.st != adc_trig_pkg::ST_SAMPLE))
    else $error("blocked timer started a conversion");
  a_dma_each: assert property (@(posedge clk) disable iff (!rst_n)
    conv_end && q.dma_en && q.dma_lvl |=> dma_req ##0 (dma_data == $past(sample_data)))
    else $error("no DMA request after conversion");
  a_hang_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    q.hung |=> (q.hung && conversion_busy_flag) [*2])
    else $error("hung converter released without reset");
  a_busy_stuck: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stb && (addr == `ADDR_CTRL0) && !q.en && wdata[`EN_POS] && wdata[`SC_POS] && q.ext_used
    |=> conversion_busy_flag && q.sc)
    else $error("enable with start did not stick busy");
  a_edge_stuck: assert property (@(posedge clk) disable iff (!rst_n)
    q.dma_stuck && !q.dma_lvl && conv_end |=> !dma_req)
    else $error("stuck edge DMA logic raised a request");
  a_seq_len: assert property (@(posedge clk) disable iff (!rst_n)
    conv_end && multi_channel(q.mode) && (q.chan != q.slen) && !start
    |=> (q.st == adc_trig_pkg::ST_SAMPLE) && (q.chan == $past(q.chan) + 4'h1))
    else $error("sequence did not advance to next channel");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.ifg[`IFG_CONV]) && q.ie[`IFG_CONV] |-> irq)
    else $error("unmasked event did not raise interrupt");
endmodule

// >>> dma_partner.sv
// DMA controller stand-in: one transfer per request, acknowledged after a delay.
// Assumes dma_req shares clk with the block and rises once per transfer.
`timescale 1ns/1ps
module dma_partner (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       dma_req,
  input  wire logic [3:0] delay,
  output logic            dma_ack,
  output int              n_acks
);
  logic       req_q;
  logic       pend;
  logic [3:0] cnt;
  // A rising request opens one transfer, so a level request is never acknowledged twice.
  always_ff @(posedge clk)
  begin
    req_q   <= dma_req;
    dma_ack <= 1'b0;
    if (!rst_n)
    begin
      pend   <= 1'b0;
      cnt    <= 4'h0;
      n_acks <= 0;
    end
    else if (dma_req && !req_q && !pend)
    begin
      pend <= 1'b1;
      cnt  <= delay;
    end
    else if (pend && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (pend)
    begin
      pend    <= 1'b0;
      dma_ack <= 1'b1;
      n_acks  <= n_acks + 1;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench of the conversion trigger control.
// Assumes the design files and dma_partner.sv are compiled before it.
`timescale 1ns/1ps
`include "adc_trig_defines.svh"
module tb_top;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic [4:0]  timer_trig;
  logic        sleep34;
  logic        ref_pwr;
  logic        gate;
  logic        dma_req;
  logic        dma_ack;
  logic [11:0] dma_data;
  logic        busy;
  logic        irq;
  logic [31:0] q;
  int          n_acks;
  int          bad_count;
  int          n_tests;
  localparam logic [11:0] SD = 12'hA5C;
  adc_trig_ctrl dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_trig(timer_trig),
    .deep_sleep_three_four(sleep34), .reference_power_bit(ref_pwr),
    .subsystem_clock_gate_bit(gate), .sample_data(SD), .dma_ack(dma_ack),
    .dma_req(dma_req), .dma_data(dma_data), .conversion_busy_flag(busy), .irq(irq));
  dma_partner dma_u (.clk(clk), .rst_n(rst_n), .dma_req(dma_req), .delay(4'h6),
    .dma_ack(dma_ack), .n_acks(n_acks));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a);
    begin
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      q = rdata;
    end
  endtask
  task settle;
    repeat (2) @(negedge clk);
  endtask
  // Waits for busy to rise, then counts the cycles it stays high.
  task run(output int n);
    int k;
    begin
      n = 0;
      k = 0;
      @(negedge clk);
      while (busy !== 1'b1 && k < 4)
      begin
        @(negedge clk);
        k++;
      end
      chk(busy, 1'b1);
      while (busy !== 1'b0 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      chk(busy, 1'b0);
    end
  endtask
  task swstart(input logic [31:0] c1, input logic [31:0] c0);
    begin
      wr(`ADDR_IFG, 32'h7);
      wr(`ADDR_CTRL1, c1);
      wr(`ADDR_CTRL0, c0 | 32'h3);
      wr(`ADDR_CTRL0, c0 | 32'h7);
    end
  endtask
  task t_reset;
    begin
      wr(8'h1C, 32'hFFFFFFFF);
      for (int i = 0; i < 8; i++)
      begin
        rd(8'(i * 4));
        chk(q, (i == 2) ? 32'h8 : 32'h0);
      end
      chk({busy, irq, dma_req}, 3'h0);
      $display("reset test done");
    end
  endtask
  task t_suspect;
    logic [3:0] v;
    logic       e;
    begin
      for (int i = 0; i < 64; i++)
      begin
        v = i[3:0];
        e = !i[4] && !i[5] && (!v[0] || v == 4'hB);
        wr(`ADDR_CTRL1, {18'h0, v, 10'h0});
        wr(`ADDR_CTRL0, {24'h0, i[5] ? 4'h6 : 4'h5, i[4], 3'h0});
        rd(`ADDR_STATUS);
        chk(q[3], e);
      end
      $display("sample mode test done");
    end
  endtask
  task t_single;
    int n;
    begin
      wr(`ADDR_IE, 32'h1);
      swstart(32'h80, 32'h40);
      run(n);
      chk(n >= 34 && n <= 40, 1'b1);
      rd(`ADDR_CTRL0);
      chk(q[2], 1'b0);
      rd(`ADDR_RESULT);
      chk(q, {20'h0, SD});
      chk(irq, 1'b1);
      wr(`ADDR_IE, 32'h0);
      settle;
      chk(irq, 1'b0);
      wr(`ADDR_IE, 32'h1);
      settle;
      chk(irq, 1'b1);
      wr(`ADDR_IFG, 32'h1);
      settle;
      chk(irq, 1'b0);
      $display("single test done");
    end
  endtask
  task t_dma;
    int n;
    int a;
    begin
      wr(`ADDR_DMA, 32'h1);
      rd(`ADDR_STATUS);
      chk(q[4], 1'b1);
      // First pass runs edge mode while stuck, then level clears it, then edge works again.
      for (int j = 0; j < 3; j++)
      begin
        wr(`ADDR_DMA, (j == 1) ? 32'h3 : 32'h1);
        a = n_acks;
        swstart(32'h0, 32'h10);
        run(n);
        repeat (12) @(negedge clk);
        chk(n_acks - a, j != 0);
        rd(`ADDR_STATUS);
        chk(q[4], j == 0);
      end
      wr(`ADDR_DMA, 32'h3);
      a = n_acks;
      swstart(32'h8001, 32'h10);
      run(n);
      repeat (12) @(negedge clk);
      chk(n_acks - a, 3);
      chk(dma_data, SD);
      rd(`ADDR_IFG);
      chk(q[1:0], 2'h3);
      $display("dma test done");
    end
  endtask
  task t_overrun;
    int n;
    begin
      for (int k = 0; k < 7; k++)
      begin
        swstart(32'(k < 4 ? k : k - 3) | 32'h4000, 32'h10);
        repeat (4) @(posedge clk);
        wr(`ADDR_CTRL0, k < 4 ? 32'h17 : 32'h11);
        repeat (40) @(negedge clk);
        rd(`ADDR_STATUS);
        chk(q[1:0], k ? 2'h3 : 2'h0);
        rd(`ADDR_IFG);
        chk(q[2], k == 0);
        wr(`ADDR_CTRL0, 32'h0);
        settle;
        chk(busy, 1'b0);
      end
      swstart(32'h0, 32'h10);
      run(n);
      rd(`ADDR_IFG);
      chk(q[0], 1'b1);
      $display("overrun test done");
    end
  endtask
  task t_timer;
    int n;
    int k;
    begin
      for (int j = 0; j < 10; j++)
      begin
        k = j % 5 + 1;
        wr(`ADDR_CTRL1, 32'(k) << 2);
        wr(`ADDR_CTRL0, 32'h12);
        wr(`ADDR_CTRL0, 32'h13);
        sleep34 <= j < 5;
        timer_trig[k-1] <= 1'b1;
        repeat (8) @(negedge clk);
        chk(busy, j >= 5 || k < 3);
        @(posedge clk);
        timer_trig <= 5'h00;
        repeat (30) @(negedge clk);
        chk(busy, 1'b0);
      end
      wr(`ADDR_CTRL1, 32'h0);
      wr(`ADDR_CTRL0, 32'h2);
      wr(`ADDR_CTRL0, 32'h7);
      settle;
      rd(`ADDR_STATUS);
      chk(q[1:0], 2'h3);
      rd(`ADDR_CTRL0);
      chk(q[2], 1'b1);
      wr(`ADDR_CTRL0, 32'h0);
      settle;
      chk(busy, 1'b0);
      swstart(32'h0, 32'h10);
      run(n);
      rd(`ADDR_IFG);
      chk(q[0], 1'b1);
      $display("timer test done");
    end
  endtask
  task t_hang;
    begin
      @(posedge clk);
      gate <= 1'b1;
      for (int d = 1; d < 3; d++)
      begin
        wr(`ADDR_CTRL1, 32'h60 | (32'(d) << 7));
        wr(`ADDR_CTRL1, 32'(d) << 7);
        wr(`ADDR_CTRL0, 32'h0);
        rd(`ADDR_STATUS);
        chk(q[2], d == 2);
      end
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`ADDR_STATUS);
      chk(q[2], 1'b0);
      $display("clock switch test done");
    end
  endtask
  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    timer_trig = 5'h00;
    sleep34 = 1'b0;
    ref_pwr = 1'b0;
    gate = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_suspect;
    t_single;
    t_dma;
    t_overrun;
    t_timer;
    t_hang;
    finish_test;
  end
  initial
  begin
    #3000000;
    bad_count++;
    finish_test;
  end
endmodule
